// ===== src/serial_io_defines.vh
// register offsets, field positions and reset values for the serial port
// assumes a 32-bit apb slave, one register per aligned word
`ifndef SERIAL_IO_DEFINES_VH
`define SERIAL_IO_DEFINES_VH
`define ADDR_BUFFER      12'h000
`define ADDR_STATUS      12'h004
`define ADDR_CONTROL     12'h008
`define ADDR_UART_CTRL   12'h00C
`define ADDR_BAUD        12'h010
`define ADDR_COLLISION   12'h014
// status bits
`define ST_TBE           0
`define ST_RBF           1
`define ST_TSC           2
`define ST_OVR           3
`define ST_PAR           4
`define ST_FRM           5
`define ST_SUM           6
`define STATUS_RESET     8'h05
// control bits
`define CT_SYNC_MODE     0
`define CT_EXT_CLK       1
`define CT_SRC_SEL       2
`define CT_READY_EN      3
`define CT_TX_EN         4
`define CT_RX_EN         5
`define CT_SERIAL_EN     6
`define CONTROL_RESET    8'h00
// uart control bits
`define UC_PARITY_EN     0
`define UC_PARITY_ODD    1
`define UC_TWO_STOP      2
`define UART_CTRL_RESET  8'h00
`define BAUD_RESET       8'h00
// timing counts
`define PRE_DIV_FAST     4
`define PRE_DIV_SLOW     16
`define SYNC_DIV         4
`define UART_DIV         16
`endif

// ===== src/serial_io.v
// serial port: buffer, status flags, baud generator, sync and uart engines
// assumes apb master on CLOCK_I; external serial clock and rx sampled here
// What this block does
// - moves 8-bit words, sync or uart mode
// - tx and rx buffers share one address
// - sync internal clock: buffer write starts transfer
// - sync external clock: write drives ready low
// - uart: buffer write starts transmission
// - tx empty clears on write, sets on load
// - rx full sets on store, clears on read
// - shift complete clears at start, sets at end
// - overrun when new byte completes before read
// - parity error on mismatch in uart parity
// - framing error checks first stop bit only
// - summing error sets on any error, clears only with all error flags
// - error flags cleared by writing rx-enable low, status write
// - baud generator reloads, divides by n+1
// - source is clock over 4 or 16
// - bit clock is generator over 4/16
// - uart control ignored in sync mode
// - uart collision raises bus arbitration request
// - sync: shift out falling, sample rising
// - ready returns high at first falling edge
//
// Design decisions made here: the register addresses and register access over APB.
`include "serial_io_defines.vh"
module serial_io (
    input  wire        CLOCK_I,
    input  wire        RST_N_I,
    input  wire        PSEL_I,
    input  wire        PENABLE_I,
    input  wire        PWRITE_I,
    input  wire [11:0] PADDR_I,
    input  wire [31:0] PWDATA_I,
    output reg  [31:0] PRDATA_O,
    output reg         PREADY_O,
    output reg         PSLVERR_O,
    input  wire        RXD_I,
    output reg         TXD_O,
    input  wire        SCLK_I,
    output reg         SCLK_O,
    output reg         SCLK_OE_O,
    output reg         SERIAL_READY_OUT_N_O,
    output reg         BUS_ARB_REQ_O
);
    reg  [7:0] status_q, control_q, uart_ctrl_q, baud_q, collision_q, rx_buf_q, tx_buf_q;
    reg  [3:0] pre_cnt_q;
    reg  [7:0] brg_cnt_q;
    reg  [3:0] bit_div_q;
    reg  [2:0] sclk_sync_q, rxd_sync_q;
    reg        sclk_lvl_q, rxd_lvl_q;
    reg        int_sclk_q;
    reg  [7:0] tx_sh_q, rx_sh_q;
    reg  [3:0] tx_bits_q, rx_bits_q;
    reg        tx_busy_q, rx_busy_q;
    reg  [3:0] tx_phase_q;
    reg        tx_par_q, rx_par_q;
    reg  [3:0] rx_tick_q;
    reg        last_tx_q;
    wire       sync_mode = control_q[`CT_SYNC_MODE];
    wire       ext_clk   = control_q[`CT_EXT_CLK];
    wire       setup_ok  = PSEL_I & ~PENABLE_I;
    wire       access    = PSEL_I & PENABLE_I & PREADY_O;
    wire       wr_buf    = access & PWRITE_I & (PADDR_I == `ADDR_BUFFER);
    wire       rd_buf    = access & ~PWRITE_I & (PADDR_I == `ADDR_BUFFER);
    wire       wr_stat   = access & PWRITE_I & (PADDR_I == `ADDR_STATUS);
    wire       wr_ctrl   = access & PWRITE_I & (PADDR_I == `ADDR_CONTROL);
    // uart format bits only matter in uart mode
    wire       par_en    = ~sync_mode & uart_ctrl_q[`UC_PARITY_EN];
    wire       par_odd   = uart_ctrl_q[`UC_PARITY_ODD];
    wire       two_stop  = ~sync_mode & uart_ctrl_q[`UC_TWO_STOP];
    // prescaler and baud generator; terminal counts cut to the 4-bit counters
    localparam integer PRE_FAST_M1 = `PRE_DIV_FAST - 1;
    localparam integer PRE_SLOW_M1 = `PRE_DIV_SLOW - 1;
    localparam integer SYNC_M1     = `SYNC_DIV - 1;
    localparam integer UART_M1     = `UART_DIV - 1;
    wire [3:0] pre_top   = control_q[`CT_SRC_SEL] ? PRE_SLOW_M1[3:0] : PRE_FAST_M1[3:0];
    wire       pre_tick  = (pre_cnt_q >= pre_top);
    wire       brg_tick  = pre_tick & (brg_cnt_q == 8'h00);
    wire [3:0] bit_top   = sync_mode ? SYNC_M1[3:0] : UART_M1[3:0];
    wire       bit_tick  = brg_tick & (bit_div_q >= bit_top);
    wire       half_tick = brg_tick & (bit_div_q == {1'b0, bit_top[3:1]});
    // serial clock edges, internal or from the pin
    wire       sclk_now  = ext_clk ? sclk_lvl_q : int_sclk_q;
    reg        sclk_prev_q;
    wire       sclk_fall = sync_mode & sclk_prev_q & ~sclk_now;
    wire       sclk_rise = sync_mode & ~sclk_prev_q & sclk_now;
    wire       tx_load   = ~status_q[`ST_TBE] & control_q[`CT_TX_EN] & ~tx_busy_q;
    // first shift of a byte: first falling sclk, or the start bit in uart
    wire       tx_first  = tx_busy_q & ((sclk_fall & (tx_bits_q == 4'h0))
                                        | (~sync_mode & bit_tick & (tx_phase_q == 4'h0)));
    wire       rx_done_sync;
    wire       rx_done_uart;
    wire       rx_done   = rx_done_sync | rx_done_uart;
    wire       par_bad, frm_bad;
    // apb slave: one wait-free access, unmapped reads as zero with error
    always @(posedge CLOCK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            PREADY_O    <= 1'b0;
            PRDATA_O    <= 32'h00000000;
            PSLVERR_O   <= 1'b0;
        end
        else
        begin
            PREADY_O  <= setup_ok;
            PSLVERR_O <= 1'b0;
            PRDATA_O  <= 32'h00000000;
            if (setup_ok)
            begin
                if (PADDR_I == `ADDR_BUFFER)
                    PRDATA_O <= {24'h000000, rx_buf_q};
                else if (PADDR_I == `ADDR_STATUS)
                    PRDATA_O <= {24'h000000, status_q};
                else if (PADDR_I == `ADDR_CONTROL)
                    PRDATA_O <= {24'h000000, control_q};
                else if (PADDR_I == `ADDR_UART_CTRL)
                    PRDATA_O <= {24'h000000, uart_ctrl_q};
                else if (PADDR_I == `ADDR_BAUD)
                    PRDATA_O <= {24'h000000, baud_q};
                else if (PADDR_I == `ADDR_COLLISION)
                    PRDATA_O <= {24'h000000, collision_q};
                else
                    PSLVERR_O <= 1'b1;
            end
        end
    end
    // writable configuration registers
    always @(posedge CLOCK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            control_q   <= `CONTROL_RESET;
            uart_ctrl_q <= `UART_CTRL_RESET;
            baud_q      <= `BAUD_RESET;
            collision_q <= 8'h00;
            tx_buf_q    <= 8'h00;
        end
        else
        begin
            if (wr_ctrl)
                control_q <= PWDATA_I[7:0];
            if (access & PWRITE_I & (PADDR_I == `ADDR_UART_CTRL))
                uart_ctrl_q <= PWDATA_I[7:0];
            if (access & PWRITE_I & (PADDR_I == `ADDR_BAUD))
                baud_q <= PWDATA_I[7:0];
            if (access & PWRITE_I & (PADDR_I == `ADDR_COLLISION))
                collision_q <= PWDATA_I[7:0];
            if (wr_buf)
                tx_buf_q <= PWDATA_I[7:0];
        end
    end
    // prescaler, 8-bit reload counter and bit divider
    always @(posedge CLOCK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            pre_cnt_q  <= 4'h0;
            brg_cnt_q  <= 8'h00;
            bit_div_q  <= 4'h0;
            int_sclk_q <= 1'b1;
        end
        else
        begin
            pre_cnt_q <= pre_tick ? 4'h0 : pre_cnt_q + 4'h1;
            if (pre_tick)
                brg_cnt_q <= (brg_cnt_q == 8'h00) ? baud_q : brg_cnt_q - 8'h01;
            if (bit_tick)
                bit_div_q <= 4'h0;
            else if (brg_tick)
                bit_div_q <= bit_div_q + 4'h1;
            // internal sclk only toggles while a byte shifts, idle high
            if (!(tx_busy_q & sync_mode & ~ext_clk))
                int_sclk_q <= 1'b1;
            else if (half_tick)
                int_sclk_q <= 1'b0;
            else if (bit_tick)
                int_sclk_q <= 1'b1;
        end
    end
    // three-stage samplers; edge taken when stages two and three agree
    always @(posedge CLOCK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            sclk_sync_q <= 3'h7;
            rxd_sync_q  <= 3'h7;
            sclk_lvl_q  <= 1'b1;
            rxd_lvl_q   <= 1'b1;
            sclk_prev_q <= 1'b1;
        end
        else
        begin
            sclk_sync_q <= {sclk_sync_q[1:0], SCLK_I};
            rxd_sync_q  <= {rxd_sync_q[1:0], RXD_I};
            if (sclk_sync_q[1] == sclk_sync_q[2])
                sclk_lvl_q <= sclk_sync_q[2];
            if (rxd_sync_q[1] == rxd_sync_q[2])
                rxd_lvl_q <= rxd_sync_q[2];
            sclk_prev_q <= sclk_now;
        end
    end
    // transmitter: sync shifts on falling sclk, uart frames on bit ticks
    always @(posedge CLOCK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            tx_sh_q    <= 8'h00;
            tx_bits_q  <= 4'h0;
            tx_busy_q  <= 1'b0;
            tx_phase_q <= 4'h0;
            tx_par_q   <= 1'b0;
            TXD_O      <= 1'b1;
            last_tx_q  <= 1'b1;
        end
        else
        begin
            if (tx_load)
            begin
                tx_sh_q    <= tx_buf_q;
                tx_busy_q  <= 1'b1;
                tx_bits_q  <= 4'h0;
                tx_phase_q <= 4'h0;
                tx_par_q   <= par_odd;
            end
            else if (tx_busy_q & sync_mode & sclk_fall)
            begin
                // lsb first on each falling edge
                if (tx_bits_q == 4'h8)
                    tx_busy_q <= 1'b0;
                else
                begin
                    TXD_O     <= tx_sh_q[0];
                    last_tx_q <= tx_sh_q[0];
                    tx_sh_q   <= {1'b0, tx_sh_q[7:1]};
                    tx_bits_q <= tx_bits_q + 4'h1;
                end
            end
            else if (tx_busy_q & sync_mode & sclk_rise & (tx_bits_q == 4'h8))
                tx_busy_q <= 1'b0;
            else if (tx_busy_q & ~sync_mode & bit_tick)
            begin
                // phase 0 start, 1..8 data, then parity and stop bits
                tx_phase_q <= tx_phase_q + 4'h1;
                if (tx_phase_q == 4'h0)
                    TXD_O <= 1'b0;
                else if (tx_phase_q <= 4'h8)
                begin
                    TXD_O    <= tx_sh_q[0];
                    tx_par_q <= tx_par_q ^ tx_sh_q[0];
                    tx_sh_q  <= {1'b0, tx_sh_q[7:1]};
                end
                else if ((tx_phase_q == 4'h9) & par_en)
                    TXD_O <= tx_par_q;
                else
                    TXD_O <= 1'b1;
                last_tx_q <= TXD_O;
                if (tx_phase_q == 4'h9 + {3'h0, par_en} + {3'h0, two_stop} + 4'h1)
                    tx_busy_q <= 1'b0;
            end
            // idle line high in both modes, so a mode change shows no false start bit
            else if (!tx_busy_q)
                TXD_O <= 1'b1;
        end
    end
    // receiver: sync samples on rising sclk, uart checks mid-bit
    reg        rx_sync_done_q, rx_uart_done_q, par_bad_q, frm_bad_q;
    assign rx_done_sync = rx_sync_done_q;
    assign rx_done_uart = rx_uart_done_q;
    assign par_bad      = par_bad_q;
    assign frm_bad      = frm_bad_q;
    always @(posedge CLOCK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            rx_sh_q        <= 8'h00;
            rx_bits_q      <= 4'h0;
            rx_busy_q      <= 1'b0;
            rx_tick_q      <= 4'h0;
            rx_par_q       <= 1'b0;
            rx_sync_done_q <= 1'b0;
            rx_uart_done_q <= 1'b0;
            par_bad_q      <= 1'b0;
            frm_bad_q      <= 1'b0;
        end
        else
        begin
            rx_sync_done_q <= 1'b0;
            rx_uart_done_q <= 1'b0;
            par_bad_q      <= 1'b0;
            frm_bad_q      <= 1'b0;
            if (!control_q[`CT_RX_EN])
            begin
                rx_busy_q <= 1'b0;
                rx_bits_q <= 4'h0;
            end
            else if (sync_mode)
            begin
                if (sclk_rise)
                begin
                    rx_sh_q <= {rxd_lvl_q, rx_sh_q[7:1]};
                    rx_bits_q <= (rx_bits_q == 4'h7) ? 4'h0 : rx_bits_q + 4'h1;
                    rx_sync_done_q <= (rx_bits_q == 4'h7);
                end
            end
            else if (!rx_busy_q)
            begin
                if (!rxd_lvl_q)
                begin
                    rx_busy_q <= 1'b1;
                    rx_bits_q <= 4'h0;
                    rx_tick_q <= 4'h0;
                    rx_par_q  <= par_odd;
                end
            end
            else if (brg_tick)
            begin
                // sample at tick 8 of each sixteen
                rx_tick_q <= rx_tick_q + 4'h1;
                if (rx_tick_q == 4'h7)
                begin
                    rx_bits_q <= rx_bits_q + 4'h1;
                    if (rx_bits_q == 4'h0)
                    begin
                        // line back high at mid start bit: a glitch, not a frame
                        if (rxd_lvl_q)
                            rx_busy_q <= 1'b0;
                    end
                    else if ((rx_bits_q >= 4'h1) & (rx_bits_q <= 4'h8))
                    begin
                        rx_sh_q  <= {rxd_lvl_q, rx_sh_q[7:1]};
                        rx_par_q <= rx_par_q ^ rxd_lvl_q;
                    end
                    else if ((rx_bits_q == 4'h9) & par_en)
                        par_bad_q <= rx_par_q ^ rxd_lvl_q;
                    else
                    begin
                        // only the first stop bit is checked
                        frm_bad_q      <= ~rxd_lvl_q;
                        rx_uart_done_q <= 1'b1;
                        rx_busy_q      <= 1'b0;
                    end
                end
            end
        end
    end
    // status flags: hardware set wins over software clear
    always @(posedge CLOCK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            status_q <= `STATUS_RESET;
            rx_buf_q <= 8'h00;
        end
        else
        begin
            if (tx_load)
                status_q[`ST_TBE] <= 1'b1;
            else if (wr_buf)
                status_q[`ST_TBE] <= 1'b0;
            if (tx_first)
                status_q[`ST_TSC] <= 1'b0;
            else if (!tx_busy_q & !tx_load)
                status_q[`ST_TSC] <= 1'b1;
            if (rx_done)
            begin
                rx_buf_q <= rx_sh_q;
                status_q[`ST_RBF] <= 1'b1;
            end
            else if (rd_buf)
                status_q[`ST_RBF] <= 1'b0;
            if (wr_stat | (wr_ctrl & ~PWDATA_I[`CT_RX_EN]))
                status_q[`ST_SUM:`ST_OVR] <= 4'h0;
            else if (wr_ctrl & ~PWDATA_I[`CT_SERIAL_EN])
                status_q[`ST_OVR] <= 1'b0;
            if (rx_done & status_q[`ST_RBF] & ~rd_buf)
            begin
                status_q[`ST_OVR] <= 1'b1;
                status_q[`ST_SUM] <= 1'b1;
            end
            if (par_bad | frm_bad)
                status_q[`ST_SUM] <= 1'b1;
            if (par_bad)
                status_q[`ST_PAR] <= 1'b1;
            if (frm_bad)
                status_q[`ST_FRM] <= 1'b1;
        end
    end
    // pins: ready, sclk drive and collision request
    always @(posedge CLOCK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            SERIAL_READY_OUT_N_O <= 1'b1;
            SCLK_O               <= 1'b1;
            SCLK_OE_O            <= 1'b0;
            BUS_ARB_REQ_O        <= 1'b0;
        end
        else
        begin
            if (sclk_fall)
                SERIAL_READY_OUT_N_O <= 1'b1;
            else if (wr_buf & sync_mode & ext_clk & control_q[`CT_READY_EN])
                SERIAL_READY_OUT_N_O <= 1'b0;
            SCLK_O    <= int_sclk_q;
            SCLK_OE_O <= sync_mode & ~ext_clk;
            // compare driven bit against line mid-bit; one-cycle pulse
            BUS_ARB_REQ_O <= collision_q[0] & tx_busy_q & ~sync_mode & half_tick
                             & (last_tx_q != rxd_lvl_q) & (TXD_O == last_tx_q);
        end
    end
endmodule // serial_io

// ===== sim/serial_io_assertions.sv
// checker on serial_io ports: apb answer, ready line, arbitration pulse
// assumes it is bound into serial_io and sees only that module's ports
`include "serial_io_defines.vh"
module serial_io_checker (
    input logic        CLOCK_I,
    input logic        RST_N_I,
    input logic        PSEL_I,
    input logic        PENABLE_I,
    input logic        PWRITE_I,
    input logic [11:0] PADDR_I,
    input logic [31:0] PWDATA_I,
    input logic [31:0] PRDATA_O,
    input logic        PREADY_O,
    input logic        PSLVERR_O,
    input logic        SCLK_I,
    input logic        SERIAL_READY_OUT_N_O,
    input logic        BUS_ARB_REQ_O
);
    logic [7:0] ctrl_q;
    logic       acc;
    // completed access, the only edge at which a write lands
    assign acc = PSEL_I && PENABLE_I && PREADY_O;
    // shadow of the mode bits, so mode-dependent checks know the mode
    always_ff @(posedge CLOCK_I or negedge RST_N_I)
        if (!RST_N_I)
            ctrl_q <= `CONTROL_RESET;
        else if (acc && PWRITE_I && PADDR_I == `ADDR_CONTROL)
            ctrl_q <= PWDATA_I[7:0];
    default clocking @(posedge CLOCK_I); endclocking
    default disable iff (!RST_N_I);
    sequence s_setup;
        PSEL_I && !PENABLE_I;
    endsequence
    sequence s_access;
        PSEL_I && PENABLE_I;
    endsequence
    sequence s_buf_write;
        acc && PWRITE_I && PADDR_I == `ADDR_BUFFER;
    endsequence
    a_ready_in_access: assert property (s_setup ##1 s_access |-> PREADY_O)
        else $error("access phase without ready");
    a_ready_one_cycle: assert property (PREADY_O |=> !PREADY_O)
        else $error("ready held too long");
    a_err_with_ready: assert property (PSLVERR_O |-> PREADY_O)
        else $error("error without ready");
    a_unmapped_err: assert property (acc && PADDR_I > `ADDR_COLLISION |-> PSLVERR_O)
        else $error("unmapped access not refused");
    a_byte_lane: assert property (PREADY_O |-> PRDATA_O[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    a_ready_on_write: assert property (s_buf_write ##0 (ctrl_q[0] && ctrl_q[1] && ctrl_q[3])
        |-> ##[1:3] !SERIAL_READY_OUT_N_O)
        else $error("buffer write left ready high");
    a_ready_back_high: assert property (!SERIAL_READY_OUT_N_O && $fell(SCLK_I)
        |-> ##[1:8] SERIAL_READY_OUT_N_O)
        else $error("ready not released after clock fall");
    a_ready_async_idle: assert property (!ctrl_q[0] && !$past(ctrl_q[0]) |-> SERIAL_READY_OUT_N_O)
        else $error("ready driven outside sync mode");
    a_arb_pulse: assert property (BUS_ARB_REQ_O |=> !BUS_ARB_REQ_O)
        else $error("arbitration request longer than a pulse");
endmodule // serial_io_checker
bind serial_io serial_io_checker i_chk (
    .CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
    .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
    .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .SCLK_I(SCLK_I),
    .SERIAL_READY_OUT_N_O(SERIAL_READY_OUT_N_O), .BUS_ARB_REQ_O(BUS_ARB_REQ_O)
);

// ===== sim/serial_peer.sv
// far-side peer: uart frames, external sync clock, echo of the shared line
// assumes the bench calls its tasks; the line idles high like a pulled-up wire
module serial_peer (
    input  wire logic clk_i,
    input  wire logic txd_i,
    output wire logic rxd_o,
    output logic      sclk_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic drive_q = 1'b0;
    logic bit_q = 1'b1;
    logic collide_q = 1'b0;
    // own bits win, else the wire echoes the device; a collision pulls it low
    assign rxd_o = collide_q ? 1'b0 : (drive_q ? bit_q : txd_i);
    initial sclk_o = 1'b1;
    // one frame lsb first, even parity, one stop; bad bits only on request
    task automatic send(input logic [7:0] d, input logic bad_par, input logic bad_stop, input int bclk);
        logic [10:0] f;
        f = {~bad_stop, ^d ^ bad_par, d, 1'b0};
        for (int i = 0; i < 11; i++)
        begin
            @(posedge clk_i);
            drive_q <= 1'b1;
            bit_q   <= f[i];
            repeat (bclk - 1) @(posedge clk_i);
        end
        @(posedge clk_i);
        drive_q <= 1'b0;
    endtask
    // eight pulses, falling edge first; clock stands high between bytes
    task automatic clock_byte(input int half);
        repeat (8)
        begin
            repeat (half) @(posedge clk_i);
            sclk_o <= 1'b0;
            repeat (half) @(posedge clk_i);
            sclk_o <= 1'b1;
        end
    endtask
endmodule // serial_peer

// ===== sim/testbench.sv
// self-checking bench for serial_io over apb, with a looped-back peer
// assumes the peer echoes the device's own line unless it sends a frame
`include "serial_io_defines.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic        pready, pslverr, rxd, txd, sclk_in, sclk_out, sclk_oe, rdy_n, arb, peer_sclk;
    logic [33:0] notes[$];
    logic [33:0] note;
    logic [7:0]  b;
    int          n_mismatch = 0;
    int          n_compared = 0;
    int          arb_cnt = 0;
    int          len, n, src;
    serial_io i_dut (
        .CLOCK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
        .RXD_I(rxd), .TXD_O(txd), .SCLK_I(sclk_in), .SCLK_O(sclk_out), .SCLK_OE_O(sclk_oe),
        .SERIAL_READY_OUT_N_O(rdy_n), .BUS_ARB_REQ_O(arb)
    );
    serial_peer i_peer (.clk_i(clk), .txd_i(txd), .rxd_o(rxd), .sclk_o(peer_sclk));
    // the clock pin is shared: whoever enables drives it
    assign sclk_in = sclk_oe ? sclk_out : peer_sclk;
    always #20 clk = ~clk;
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one apb transfer; note is {check data, expect error, data}
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [33:0] nt);
        int k;
        k = 0;
        notes.push_back(nt);
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k == 50)
            chk("pready", 1, pready);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h000000, d}, 34'h000000000);
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 32'h00000000, {2'b10, 24'h000000, e});
    endtask
    task automatic tx(input logic [7:0] d, input int cyc);
        wr(`ADDR_BUFFER, d);
        repeat (cyc) @(posedge clk);
    endtask
    // length of the start bit in clocks; needs data bit 0 high
    task automatic start_bit(input int exp);
        int k;
        k = 0;
        len = 0;
        while (txd !== 1'b0 && k < 5000)
        begin
            @(posedge clk);
            k++;
        end
        while (txd === 1'b0 && len < 5000)
        begin
            @(posedge clk);
            len++;
        end
        chk("start bit", exp, len);
    endtask
    // answer monitor: oldest note against each completed transfer
    always @(posedge clk)
        if (psel && penable && pready)
        begin
            note = notes.pop_front();
            chk("slverr", note[32], pslverr);
            if (note[33])
                chk($sformatf("rdata at %h", paddr), note[31:0], prdata);
        end
    always @(posedge clk)
        if (arb === 1'b1)
            arb_cnt++;
    task automatic results();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // watchdog, well above the longest expected run
    initial
    begin
        repeat (90000) @(posedge clk);
        n_mismatch++;
        results();
    end
    initial
    begin
        void'($urandom(32'h6736));
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd(`ADDR_STATUS, `STATUS_RESET);
        rd(`ADDR_BAUD, `BAUD_RESET);
        apb(1'b0, 12'h018, 32'h00000000, {2'b11, 32'h00000000});
        apb(1'b1, 12'h018, 32'h000000FF, {2'b01, 32'h00000000});
        wr(`ADDR_UART_CTRL, 8'h03);
        wr(`ADDR_CONTROL, 8'h71);
        b = 8'($urandom);
        tx(b, 20);
        chk("sclk drive", 1, sclk_oe);
        repeat (200) @(posedge clk);
        rd(`ADDR_STATUS, 8'h07);
        rd(`ADDR_BUFFER, b);
        rd(`ADDR_STATUS, 8'h05);
        tx(b, 220);
        tx(~b, 220);
        rd(`ADDR_STATUS, 8'h4F);
        wr(`ADDR_STATUS, 8'h00);
        rd(`ADDR_STATUS, 8'h07);
        tx(b, 220);
        wr(`ADDR_CONTROL, 8'h31);
        rd(`ADDR_STATUS, 8'h47);
        wr(`ADDR_CONTROL, 8'h7B);
        b = 8'($urandom);
        tx(b, 10);
        chk("ready", 0, rdy_n);
        i_peer.clock_byte(10);
        repeat (20) @(posedge clk);
        chk("ready", 1, rdy_n);
        rd(`ADDR_BUFFER, b);
        rd(`ADDR_STATUS, 8'h4D);
        wr(`ADDR_STATUS, 8'h00);
        wr(`ADDR_UART_CTRL, 8'h01);
        for (int i = 0; i < 3; i++)
        begin
            n = (i == 0) ? 0 : $urandom % 3;
            src = (i == 0) ? 0 : $urandom % 2;
            wr(`ADDR_BAUD, 8'(n));
            wr(`ADDR_CONTROL, src ? 8'h74 : 8'h70);
            b = 8'($urandom) | 8'h01;
            wr(`ADDR_BUFFER, b);
            start_bit(16 * (n + 1) * (src ? 16 : 4));
            rd(`ADDR_STATUS, 8'h01);
            repeat (11 * len) @(posedge clk);
            rd(`ADDR_BUFFER, b);
            rd(`ADDR_STATUS, 8'h05);
        end
        wr(`ADDR_BAUD, 8'h00);
        wr(`ADDR_CONTROL, 8'h70);
        i_peer.send(b, 1'b1, 1'b0, 64);
        rd(`ADDR_STATUS, 8'h57);
        wr(`ADDR_STATUS, 8'h00);
        rd(`ADDR_STATUS, 8'h07);
        rd(`ADDR_BUFFER, b);
        i_peer.send(~b, 1'b0, 1'b1, 64);
        rd(`ADDR_STATUS, 8'h67);
        wr(`ADDR_CONTROL, 8'h50);
        rd(`ADDR_STATUS, 8'h07);
        wr(`ADDR_CONTROL, 8'h70);
        wr(`ADDR_COLLISION, 8'h01);
        @(posedge clk);
        i_peer.collide_q <= 1'b1;
        tx(8'hFF, 800);
        chk("arbitration seen", 1, arb_cnt > 0);
        results();
    end
endmodule // testbench
